/* design/pbcg_clock_gate.sv */
// register block gating third bus clock group plus clock-ready interrupt
`timescale 1ns/1ps
module pbcg_clock_gate
    import pbcg_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // axi4-lite slave
    input wire logic s_axi_awvalid_in,
    input wire logic [AXI_AW-1:0] s_axi_awaddr_in,
    output logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic [AXI_DW-1:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_wready_out,
    output logic s_axi_bvalid_out,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic [AXI_AW-1:0] s_axi_araddr_in,
    output logic s_axi_arready_out,
    output logic s_axi_rvalid_out,
    output logic [AXI_DW-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rready_in,
    // clock system reports divided clocks have settled
    input wire logic clocks_settled_in,
    // gated clock enables
    output pbcg_bus_c_en_s bus_c_clk_en_out,
    output logic access_protect_one_clk_en_out,
    output logic irq_out
);

    // ---------------- write channel capture ----------------
    logic awready_r;
    logic wready_r;
    logic aw_held_r;
    logic w_held_r;
    // one flop group per capture process, gathered into one command word
    logic [IDX_W-1:0] wr_idx_r;
    logic [AXI_DW-1:0] wr_data_r;
    logic [3:0] wr_strb_r;
    pbcg_wr_cmd_s cmd_r;
    pbcg_wr_state_e wr_state_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_go;
    logic aw_take;
    logic w_take;

    assign aw_take = s_axi_awvalid_in & awready_r;
    assign w_take = s_axi_wvalid_in & wready_r;
    assign cmd_r = {wr_idx_r, wr_data_r, wr_strb_r};
    // commit once both halves are held and no answer is pending
    assign wr_go = aw_held_r & w_held_r & (wr_state_r == WR_COLLECT);

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_held_r <= 1'b0;
            awready_r <= 1'b1;
            wr_idx_r <= '0;
        end else if (aw_take) begin
            aw_held_r <= 1'b1;
            awready_r <= 1'b0;
            wr_idx_r <= s_axi_awaddr_in[AXI_AW-1:2];
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            w_held_r <= 1'b0;
            wready_r <= 1'b1;
            wr_data_r <= '0;
            wr_strb_r <= '0;
        end else if (w_take) begin
            w_held_r <= 1'b1;
            wready_r <= 1'b0;
            wr_data_r <= s_axi_wdata_in;
            wr_strb_r <= s_axi_wstrb_in;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
            wready_r <= 1'b1;
        end
    end

    // ---------------- register state ----------------
    pbcg_bus_c_en_s bus_c_mask_r;
    logic ap_one_r;
    logic irq_en_r;
    logic irq_flag_r;
    logic protect_r;
    logic irq_r;

    // ---------------- write decode ----------------
    logic hit_bus_b;
    logic hit_bus_c;
    logic hit_en_clr;
    logic hit_en_set;
    logic hit_flag;
    logic hit_protect;
    logic wr_mapped;
    logic protected_hit;
    logic wr_blocked;
    logic wr_ok;
    logic [AXI_DW-1:0] cur_word;
    logic [AXI_DW-1:0] merged;
    logic lane0_one;

    assign hit_bus_b = (cmd_r.idx == IDX_BUS_B_MASK);
    assign hit_bus_c = (cmd_r.idx == IDX_BUS_C_MASK);
    assign hit_en_clr = (cmd_r.idx == IDX_IRQ_EN_CLR);
    assign hit_en_set = (cmd_r.idx == IDX_IRQ_EN_SET);
    assign hit_flag = (cmd_r.idx == IDX_IRQ_FLAG);
    assign hit_protect = (cmd_r.idx == IDX_WR_PROTECT);
    assign wr_mapped = hit_bus_b | hit_bus_c | hit_en_clr | hit_en_set
                     | hit_flag | hit_protect;
    // protection covers every mask and both enable registers
    assign protected_hit = hit_bus_b | hit_bus_c | hit_en_clr | hit_en_set;
    // the switch itself stays writable, or protection could never be lifted
    assign wr_blocked = protect_r & protected_hit;
    assign wr_ok = wr_go & wr_mapped & ~wr_blocked;

    // the third mask is the only multi-lane register; others use lane 0
    assign cur_word = {{(AXI_DW - BUS_C_USED_W){1'b0}}, bus_c_mask_r};

    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign merged[8*lane +: 8] = cmd_r.strb[lane] ? cmd_r.data[8*lane +: 8]
                                                          : cur_word[8*lane +: 8];
        end
    endgenerate

    assign lane0_one = cmd_r.strb[0] & cmd_r.data[CLOCK_READY_BIT];

    // ---------------- per-register write strobes ----------------
    logic we_bus_b;
    logic we_bus_c;
    logic we_protect;
    logic we_en_set;
    logic we_en_clr;
    logic we_flag_clr;

    // single-bit registers need lane 0; the third mask merges lanes instead
    assign we_bus_b = wr_ok & hit_bus_b & cmd_r.strb[0];
    assign we_bus_c = wr_ok & hit_bus_c;
    assign we_protect = wr_ok & hit_protect & cmd_r.strb[0];
    // a written zero never reaches the enable or the flag
    assign we_en_set = wr_ok & hit_en_set & lane0_one;
    assign we_en_clr = wr_ok & hit_en_clr & lane0_one;
    assign we_flag_clr = wr_ok & hit_flag & lane0_one;

    // ---------------- write response ----------------
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_state_r <= WR_COLLECT;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            case (wr_state_r)
                WR_COLLECT: begin
                    if (wr_go) begin
                        wr_state_r <= WR_RESPOND;
                        bvalid_r <= 1'b1;
                        // unmapped or protected writes answer with an error
                        bresp_r <= (wr_mapped & ~wr_blocked) ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESPOND: begin
                    if (s_axi_bready_in) begin
                        wr_state_r <= WR_COLLECT;
                        bvalid_r <= 1'b0;
                        bresp_r <= RESP_OKAY;
                    end
                end
                default: begin
                    wr_state_r <= WR_COLLECT;
                    bvalid_r <= 1'b0;
                    bresp_r <= RESP_OKAY;
                end
            endcase
        end
    end

    // ---------------- third bus clock mask ----------------
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus_c_mask_r <= RST_BUS_C_MASK[BUS_C_USED_W-1:0];
        end else if (we_bus_c) begin
            // upper twelve bits are never stored
            bus_c_mask_r <= merged[BUS_C_USED_W-1:0];
        end
    end

    // ---------------- second bus clock mask, bit 0 only ----------------
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ap_one_r <= RST_AP_ONE;
        end else if (we_bus_b) begin
            ap_one_r <= cmd_r.data[AP_ONE_BIT];
        end
    end

    // ---------------- write protection switch ----------------
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            protect_r <= RST_PROTECT;
        end else if (we_protect) begin
            protect_r <= cmd_r.data[PROTECT_BIT];
        end
    end

    // ---------------- clock-ready interrupt enable ----------------
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_en_r <= RST_IRQ_EN;
        end else if (we_en_set) begin
            irq_en_r <= 1'b1;
        end else if (we_en_clr) begin
            // a written zero leaves the enable alone
            irq_en_r <= 1'b0;
        end
    end

    // ---------------- clock-ready flag ----------------
    logic settled_rise;

    pbcg_sync2 u_settled_sync (
        .clk_in(clk_sys_in),
        .resetn_in(resetn_in),
        .async_in(clocks_settled_in),
        // only the rising edge matters here; the settled level is left open
        .level_out(),
        .rise_out(settled_rise)
    );

    // a fresh settle event beats a same-cycle software clear
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_flag_r <= RST_IRQ_FLAG;
        end else if (settled_rise) begin
            irq_flag_r <= 1'b1;
        end else if (we_flag_clr) begin
            irq_flag_r <= 1'b0;
        end
    end

    // ---------------- interrupt line ----------------
    logic irq_nxt;

    assign irq_nxt = irq_flag_r & irq_en_r;
    // lags the flag or enable by one cycle so the pin comes from a flop
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // ---------------- read channel ----------------
    logic arready_r;
    logic rvalid_r;
    logic [AXI_DW-1:0] rdata_r;
    logic [1:0] rresp_r;
    logic ar_take;
    logic [IDX_W-1:0] rd_idx;
    logic [AXI_DW-1:0] rd_word;
    logic rd_mapped;

    // reads have no side effects, so a repeated read is harmless
    assign ar_take = s_axi_arvalid_in & arready_r;
    assign rd_idx = s_axi_araddr_in[AXI_AW-1:2];

    always_comb begin
        rd_word = '0;
        rd_mapped = 1'b1;
        case (rd_idx)
            IDX_BUS_B_MASK: rd_word[AP_ONE_BIT] = ap_one_r;
            IDX_BUS_C_MASK: rd_word = cur_word;
            IDX_IRQ_EN_CLR: rd_word[CLOCK_READY_BIT] = irq_en_r;
            IDX_IRQ_EN_SET: rd_word[CLOCK_READY_BIT] = irq_en_r;
            IDX_IRQ_FLAG: rd_word[CLOCK_READY_BIT] = irq_flag_r;
            IDX_WR_PROTECT: rd_word[PROTECT_BIT] = protect_r;
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready_in) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
    end

    // ---------------- outputs ----------------
    assign s_axi_awready_out = awready_r;
    assign s_axi_wready_out = wready_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign s_axi_arready_out = arready_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;
    // enables are used as glitch-free gate controls by the clock tree
    assign bus_c_clk_en_out = bus_c_mask_r;
    assign access_protect_one_clk_en_out = ap_one_r;
    assign irq_out = irq_r;

endmodule : pbcg_clock_gate

/* design/pbcg_pkg.sv */
// package for the peripheral bus clock gate and clock-ready interrupt block
// Operation
// - mask bits 19..16 gate touch, dac, comparator, converter
// - bits 15..8 gate basic and control timers
// - bits 7..0 gate serial units, events, protect-two
// - third mask resets to 0x00010000
// - second mask bit 0 gates protect-one clock
// - zero written to enable-clear is ignored
// - one to enable-clear bit 0 disables request
// - request raised only while enabled and flag set
// - enables reset to zero, both read same
// - one to enable-set bit 0 enables interrupt
// - flag set on clocks ready, write-one clears
package pbcg_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int AXI_AW = 12;
    localparam int AXI_DW = 32;
    localparam int IDX_W = 10;

    // register index; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_BUS_B_MASK = 10'h01c;
    localparam logic [IDX_W-1:0] IDX_BUS_C_MASK = 10'h020;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN_CLR = 10'h034;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN_SET = 10'h035;
    localparam logic [IDX_W-1:0] IDX_IRQ_FLAG = 10'h036;
    localparam logic [IDX_W-1:0] IDX_WR_PROTECT = 10'h03c;

    localparam int BUS_C_USED_W = 20;
    localparam int CLOCK_READY_BIT = 0;
    localparam int PROTECT_BIT = 0;
    localparam int AP_ONE_BIT = 0;

    localparam logic [31:0] RST_BUS_C_MASK = 32'h0001_0000;
    localparam logic RST_AP_ONE = 1'b1;
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic RST_IRQ_FLAG = 1'b0;
    localparam logic RST_PROTECT = 1'b0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // bit order matches the third mask, bit 19 first
    typedef struct packed {
        logic touch_controller;
        logic dac;
        logic analog_comparator;
        logic adc;
        logic [4:0] basic_timer;
        logic [2:0] control_timer;
        logic [5:0] serial_unit;
        logic event_system;
        logic access_protect_two;
    } pbcg_bus_c_en_s;

    typedef struct packed {
        logic [IDX_W-1:0] idx;
        logic [AXI_DW-1:0] data;
        logic [3:0] strb;
    } pbcg_wr_cmd_s;

    typedef enum logic {
        WR_COLLECT,
        WR_RESPOND
    } pbcg_wr_state_e;

endpackage : pbcg_pkg

/* design/pbcg_sync2.sv */
// two-flop synchroniser with rising-edge pulse for the clocks-settled input
`timescale 1ns/1ps
module pbcg_sync2 (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out
);
    logic meta_r;
    logic level_r;
    logic prev_r;

    // meta_r feeds only level_r
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_r <= 1'b0;
            level_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            level_r <= meta_r;
            prev_r <= level_r;
        end
    end

    assign level_out = level_r;
    assign rise_out = level_r & ~prev_r;

endmodule : pbcg_sync2

/* sim/pbcg_clock_gate_sva.sv */
// concurrent checks on the clock gate block ports
`timescale 1ns/1ps
module pbcg_clock_gate_sva
    import pbcg_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic s_axi_awvalid_in,
    input wire logic [AXI_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic [AXI_DW-1:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic [AXI_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic [AXI_DW-1:0] s_axi_rdata_out,
    input wire logic s_axi_rready_in,
    input wire pbcg_bus_c_en_s bus_c_clk_en_out,
    input wire logic access_protect_one_clk_en_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    logic [AXI_AW-1:0] rd_addr_r;
    // remembers which register the pending read answers for
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_addr_r <= '0;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rd_addr_r <= s_axi_araddr_in;
        end
    end
    property p_reset_gates;
        $rose(resetn_in) |-> bus_c_clk_en_out == RST_BUS_C_MASK[19:0]
            && access_protect_one_clk_en_out;
    endproperty
    a_reset_gates: assert property (p_reset_gates)
        else $error("gate enables wrong after reset");
    property p_bresp_hold;
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response dropped before taken");
    property p_rdata_hold;
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed before taken");
    property p_write_answer;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            |-> ##[1:3] s_axi_bvalid_out;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write not answered in time");
    property p_read_answer;
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered next cycle");
    property p_mask_read;
        s_axi_rvalid_out && rd_addr_r == {IDX_BUS_C_MASK, 2'b00}
            |-> s_axi_rdata_out == {12'h000, bus_c_clk_en_out};
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask readback differs from gate enables");
    property p_gate_change;
        !$stable(bus_c_clk_en_out) || !$stable(access_protect_one_clk_en_out)
            |-> ##[0:1] s_axi_bvalid_out;
    endproperty
    a_gate_change: assert property (p_gate_change)
        else $error("gate enable moved without a write");
    property p_clear_drops_irq;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_awaddr_in == {IDX_IRQ_EN_CLR, 2'b00}
            && s_axi_wvalid_in && s_axi_wready_out && s_axi_wdata_in[0] && s_axi_wstrb_in[0]
            |-> ##[2:4] (!irq_out || (s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR));
    endproperty
    a_clear_drops_irq: assert property (p_clear_drops_irq)
        else $error("interrupt kept after enable clear");
endmodule : pbcg_clock_gate_sva

/* sim/pbcg_periph_model.sv */
// peripheral side: gated clock observers and the clock-settle source
`timescale 1ns/1ps
module pbcg_periph_model
    import pbcg_pkg::*;
(
    input wire logic clk_sys_in,
    input wire pbcg_bus_c_en_s bus_c_clk_en_in,
    input wire logic ap_one_clk_en_in,
    input wire logic clr_in,
    input wire logic settle_in,
    input wire logic [1:0] lag_in,
    output logic [20:0] ran_out,
    output logic clocks_settled_out
);
    logic [3:0] settle_r;
    // a peripheral sees an edge only while its enable is high
    always_ff @(posedge clk_sys_in) begin
        ran_out <= clr_in ? '0 : ran_out | {ap_one_clk_en_in, bus_c_clk_en_in};
    end
    // settles after a prompt or slow lag, so the sync path sees both
    always_ff @(posedge clk_sys_in) begin
        settle_r <= clr_in ? '0 : {settle_r[2:0], settle_in};
    end
    assign clocks_settled_out = settle_r[lag_in];
endmodule : pbcg_periph_model

/* sim/testbench.sv */
// self-checking bench for the clock gate block
`timescale 1ns/1ps
module testbench;
    import pbcg_pkg::*;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, clocks_settled_in;
    logic [11:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
    logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, access_protect_one_clk_en_out, irq_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, lag = 2'h0;
    logic clr = 1'b1, settle = 1'b0;
    logic [20:0] ran;
    logic [15:0] lfsr_r = 16'h483e;
    logic [11:0] regs [7] = '{12'h070, 12'h080, 12'h0d0, 12'h0d4, 12'h0d8, 12'h0f0, 12'h004};
    pbcg_bus_c_en_s bus_c_clk_en_out;
    int failures = 0, n_checks = 0, cyc = 0;
    int m_mask = 'h10000, m_ap1 = 1, m_en = 0, m_flag = 0, m_prot = 0;

    pbcg_clock_gate uut (.*);
    pbcg_periph_model far_end (.clk_sys_in(clk_sys_in), .bus_c_clk_en_in(bus_c_clk_en_out),
        .ap_one_clk_en_in(access_protect_one_clk_en_out), .clr_in(clr), .settle_in(settle),
        .lag_in(lag), .ran_out(ran), .clocks_settled_out(clocks_settled_in));

    function automatic logic [31:0] rnd();
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        return {lfsr_r, lfsr_r ^ 16'h5a5a};
    endfunction : rnd

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    function automatic logic mapped(input logic [11:0] a);
        return a inside {12'h070, 12'h080, 12'h0d0, 12'h0d4, 12'h0d8, 12'h0f0};
    endfunction : mapped

    // offers address and data together, then stalls the response a while
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic ad, wd, bad;
        logic [31:0] m;
        ad = 0;
        wd = 0;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        bad = !mapped(a) || (m_prot != 0 && a inside {12'h070, 12'h080, 12'h0d0, 12'h0d4});
        if (!bad) begin
            case (a)
                12'h070: m_ap1 = s[0] ? d[0] : m_ap1;
                12'h080: m_mask = ((m_mask & ~m) | (d & m)) & 32'h000f_ffff;
                12'h0d0: m_en = (d[0] & s[0]) ? 0 : m_en;
                12'h0d4: m_en = (d[0] & s[0]) ? 1 : m_en;
                12'h0d8: m_flag = (d[0] & s[0]) ? 0 : m_flag;
                default: m_prot = s[0] ? d[0] : m_prot;
            endcase
        end
        s_axi_awvalid_in <= 1'b1;
        s_axi_awaddr_in <= a;
        s_axi_wvalid_in <= 1'b1;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= s;
        while (!(ad && wd)) begin
            @(posedge clk_sys_in);
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                ad = 1;
                s_axi_awvalid_in <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                wd = 1;
                s_axi_wvalid_in <= 1'b0;
            end
        end
        repeat (2) @(posedge clk_sys_in);
        s_axi_bready_in <= 1'b1;
        do @(posedge clk_sys_in); while (!s_axi_bvalid_out);
        chk(s_axi_bresp_out, bad ? RESP_SLVERR : RESP_OKAY);
        s_axi_bready_in <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [11:0] a);
        int e;
        case (a)
            12'h070: e = m_ap1;
            12'h080: e = m_mask;
            12'h0d0, 12'h0d4: e = m_en;
            12'h0d8: e = m_flag;
            12'h0f0: e = m_prot;
            default: e = 0;
        endcase
        s_axi_arvalid_in <= 1'b1;
        s_axi_araddr_in <= a;
        do @(posedge clk_sys_in); while (!s_axi_arready_out);
        s_axi_arvalid_in <= 1'b0;
        @(posedge clk_sys_in);
        s_axi_rready_in <= 1'b1;
        do @(posedge clk_sys_in); while (!s_axi_rvalid_out);
        chk(s_axi_rdata_out, e);
        chk(s_axi_rresp_out, mapped(a) ? RESP_OKAY : RESP_SLVERR);
        s_axi_rready_in <= 1'b0;
    endtask : rd_chk

    task automatic outs();
        repeat (4) @(posedge clk_sys_in);
        chk(bus_c_clk_en_out, m_mask[19:0]);
        chk(access_protect_one_clk_en_out, m_ap1[0]);
        chk(irq_out, m_en[0] & m_flag[0]);
        clr <= 1'b1;
        @(posedge clk_sys_in);
        clr <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        chk(ran, {m_ap1[0], m_mask[19:0]});
    endtask : outs

    task automatic settle_ev(input logic [1:0] l);
        lag <= l;
        settle <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        m_flag = 1;
        settle <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
    endtask : settle_ev

    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    // generous ceiling; the sequence needs a few hundred cycles
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        repeat (4) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        clr <= 1'b0;
        foreach (regs[i]) rd_chk(regs[i]);
        outs();
        wr(12'h080, 32'hffffffff);
        rd_chk(12'h080);
        outs();
        for (int i = 0; i < 8; i++) begin
            wr(12'h080, rnd(), (i < 4) ? 4'hf : 4'(rnd()));
            rd_chk(12'h080);
            outs();
        end
        wr(12'h070, 32'h0);
        outs();
        wr(12'h0d4, 32'h1, 4'he);
        wr(12'h0d4, 32'hfffffffe);
        rd_chk(12'h0d4);
        settle_ev(2'h0);
        rd_chk(12'h0d8);
        outs();
        wr(12'h0d4, 32'h1);
        rd_chk(12'h0d0);
        outs();
        wr(12'h0d0, 32'hfffffffe);
        outs();
        wr(12'h0d0, 32'h1);
        rd_chk(12'h0d4);
        outs();
        wr(12'h0d8, 32'h1);
        wr(12'h0d4, 32'h1);
        settle_ev(2'h3);
        outs();
        wr(12'h0d8, 32'h1);
        outs();
        wr(12'h0f0, 32'h1);
        foreach (regs[i]) wr(regs[i], 32'h1);
        foreach (regs[i]) rd_chk(regs[i]);
        outs();
        wr(12'h0f0, 32'h0);
        @(posedge clk_sys_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        m_mask = 'h10000;
        m_ap1 = 1;
        m_en = 0;
        m_flag = 0;
        foreach (regs[i]) rd_chk(regs[i]);
        outs();
        conclude();
    end
endmodule : testbench

bind pbcg_clock_gate pbcg_clock_gate_sva chk_i (.*);
